/* core/sfbl_regs.vh */
// Purpose: Constants for the flag register and banked data memory block
// Assumes: 32-bit AXI4-Lite register window, byte addresses below
// Notes:   Definitions only

`ifndef SFBL_REGS_VH
`define SFBL_REGS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define SFBL_FLAGS_OFS 8'h00
`define SFBL_BANK_OFS 8'h04
`define SFBL_OPERAND_OFS 8'h08
`define SFBL_COMMAND_OFS 8'h0c
`define SFBL_RESULT_OFS 8'h10
`define SFBL_WIN_OFS_OFS 8'h14
`define SFBL_WIN_DATA_OFS 8'h18
`define SFBL_LIN_PTR_OFS 8'h1c
`define SFBL_LIN_DATA_OFS 8'h20

// ----------------------------------------------------------------------
// Flag register fields and reset values
// ----------------------------------------------------------------------
`define SFBL_TO_BIT 4
`define SFBL_PD_BIT 3
`define SFBL_Z_BIT 2
`define SFBL_DC_BIT 1
`define SFBL_C_BIT 0
`define SFBL_TO_RST 1'b1
`define SFBL_PD_RST 1'b1
`define SFBL_Z_RST 1'b0
`define SFBL_DC_RST 1'b0
`define SFBL_C_RST 1'b0

// ----------------------------------------------------------------------
// Bank layout
// ----------------------------------------------------------------------
`define SFBL_CORE_LAST 7'h0b
`define SFBL_FLAGS_SLOT 7'h03
`define SFBL_BSEL_SLOT 7'h08
`define SFBL_PERIPH_LAST 7'h1f
`define SFBL_GPR_FIRST 7'h20
`define SFBL_GPR_LAST 7'h6f
`define SFBL_GPR_PER_BANK 12'h050
`define SFBL_GPR_BANKS 5'h02
`define SFBL_GPR_BYTES 12'h0a0
`define SFBL_COMMON_BYTES 16
`define SFBL_RG_CORE 0
`define SFBL_RG_PERIPH 1
`define SFBL_RG_GPR 2
`define SFBL_RG_COMMON 3

// ----------------------------------------------------------------------
// Command register fields and operation codes
// ----------------------------------------------------------------------
`define SFBL_CMD_TO_FILE_BIT 4
`define SFBL_CMD_SRC_FILE_BIT 5
`define SFBL_CMD_BIT_LSB 6
`define SFBL_CMD_OFS_LSB 16
`define SFBL_OP_SUM 4'h0
`define SFBL_OP_DIFF 4'h1
`define SFBL_OP_AND 4'h2
`define SFBL_OP_OR 4'h3
`define SFBL_OP_XOR 4'h4
`define SFBL_OP_ROT_L 4'h5
`define SFBL_OP_ROT_R 4'h6
`define SFBL_OP_ZERO_FILE 4'h7
`define SFBL_OP_BIT_DROP 4'h8
`define SFBL_OP_BIT_RAISE 4'h9
`define SFBL_OP_NIBBLE_EXCH 4'ha
`define SFBL_OP_WREG_STORE 4'hb
`define SFBL_OP_WDOG_KICK 4'hc
`define SFBL_OP_SLEEP 4'hd

// ----------------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------------
`define SFBL_RESP_OKAY 2'b00
`define SFBL_RESP_SLVERR 2'b10

`endif

/* core/sfbl_alu.v */
// Purpose: Result and flag computation for one executed operation
// Assumes: Purely combinational, operands stable during the execute cycle
// Notes:   Each flag has an update enable; flags without it are left alone

`timescale 1ns/1ps

`include "sfbl_regs.vh"

module sfbl_alu (
  input wire [3:0] op,
  input wire [7:0] a,
  input wire [7:0] w,
  input wire [2:0] bit_sel,
  input wire carry_in,
  output reg [7:0] result,
  output reg wr_en,
  output reg z,
  output reg z_upd,
  output reg dc,
  output reg dc_upd,
  output reg c,
  output reg c_upd
);

  reg [8:0] sum9;
  reg [4:0] sum5;

  always @*
  begin
    sum9 = {1'b0, a} + {1'b0, w};
    sum5 = {1'b0, a[3:0]} + {1'b0, w[3:0]};
    result = 8'h00;
    wr_en = 1'b1;
    z_upd = 1'b0;
    dc_upd = 1'b0;
    c_upd = 1'b0;
    dc = 1'b0;
    c = 1'b0;
    case (op)
      `SFBL_OP_SUM:
      begin
        result = sum9[7:0];
        dc = sum5[4];
        c = sum9[8];
        z_upd = 1'b1;
        dc_upd = 1'b1;
        c_upd = 1'b1;
      end
      `SFBL_OP_DIFF:
      begin
        // Two's complement add, so a set carry means no borrow
        sum9 = {1'b0, a} + {1'b0, ~w} + 9'h001;
        sum5 = {1'b0, a[3:0]} + {1'b0, ~w[3:0]} + 5'h01;
        result = sum9[7:0];
        dc = sum5[4];
        c = sum9[8];
        z_upd = 1'b1;
        dc_upd = 1'b1;
        c_upd = 1'b1;
      end
      `SFBL_OP_AND:
      begin
        result = a & w;
        z_upd = 1'b1;
      end
      `SFBL_OP_OR:
      begin
        result = a | w;
        z_upd = 1'b1;
      end
      `SFBL_OP_XOR:
      begin
        result = a ^ w;
        z_upd = 1'b1;
      end
      `SFBL_OP_ROT_L:
      begin
        result = {a[6:0], carry_in};
        c = a[7];
        c_upd = 1'b1;
      end
      `SFBL_OP_ROT_R:
      begin
        result = {carry_in, a[7:1]};
        c = a[0];
        c_upd = 1'b1;
      end
      `SFBL_OP_ZERO_FILE:
      begin
        result = 8'h00;
        z_upd = 1'b1;
      end
      `SFBL_OP_BIT_DROP: result = a & ~(8'h01 << bit_sel);
      `SFBL_OP_BIT_RAISE: result = a | (8'h01 << bit_sel);
      `SFBL_OP_NIBBLE_EXCH: result = {a[3:0], a[7:4]};
      `SFBL_OP_WREG_STORE: result = w;
      default: wr_en = 1'b0;
    endcase
    z = (result == 8'h00);
  end

endmodule

/* core/sfbl_bank_decode.v */
// Purpose: Split a bank number and 7-bit offset into a memory region
// Assumes: Only the first banks carry general RAM
// Notes:   Region output is one-hot

`timescale 1ns/1ps

`include "sfbl_regs.vh"

module sfbl_bank_decode (
  input wire [4:0] bank,
  input wire [6:0] offset,
  output reg [3:0] region,
  output reg gpr_hit,
  output reg [7:0] gpr_index
);

  reg [11:0] lin;

  always @*
  begin
    lin = {7'h00, bank} * `SFBL_GPR_PER_BANK + {5'h00, offset} - {5'h00, `SFBL_GPR_FIRST};
    region = 4'h0;
    if (offset <= `SFBL_CORE_LAST)
      region[`SFBL_RG_CORE] = 1'b1;
    else if (offset <= `SFBL_PERIPH_LAST)
      region[`SFBL_RG_PERIPH] = 1'b1;
    else if (offset <= `SFBL_GPR_LAST)
      region[`SFBL_RG_GPR] = 1'b1;
    else
      region[`SFBL_RG_COMMON] = 1'b1;
    gpr_hit = region[`SFBL_RG_GPR] && (bank < `SFBL_GPR_BANKS);
    gpr_index = lin[7:0];
  end

endmodule

/* core/sfbl_top.v */
// Purpose: Flag register and banked data memory behind an AXI4-Lite slave
// Assumes: sys_rst is the power-on / brown-out reset; one clock
// Notes:   Operations are issued by writing the command register

`timescale 1ns/1ps

`include "sfbl_regs.vh"

// Notes on behaviour
// - Flag bits 7-5 always read zero
// - Expiry flag set on kick/sleep, cleared by time-out
// - Sleep flag set by kick, cleared by sleep
// - Result-null flag follows zero result
// - Nibble overflow is carry out of bit three
// - Msb overflow is carry out of bit seven
// - Subtract adds two's complement; carry means no-borrow
// - Rotates load msb overflow with shifted-out bit
// - Reset: expiry and sleep one, arithmetic flags zero
// - Zero-file on flags clears top, sets null
// - Peripheral registers at offsets 0Ch to 1Fh
// - Up to eighty general RAM bytes ending 6Fh
// - Offsets 70h-7Fh reach shared common RAM
// - General RAM reachable linearly through indirect pointer
// - Core registers occupy first twelve bank offsets
// - Flag-updating writes to flags suppressed; expiry/sleep read-only
// - Address is bank number over 7-bit offset
module sfbl_top (
  input wire sys_clk,
  input wire sys_rst,
  input wire wdog_timeout,
  input wire [7:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg wdog_expiry_flag,
  output reg sleep_entered_flag
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  reg result_null_flag;
  reg nibble_overflow_flag;
  reg msb_overflow_flag;
  reg [4:0] bank_select_reg;
  reg [7:0] lit_operand;
  reg [7:0] wreg_operand;
  reg [31:0] command_word;
  reg exec;
  reg [7:0] result_reg;
  reg [6:0] win_offset;
  reg [11:0] indirect_pointer;
  reg [7:0] general_ram [0:`SFBL_GPR_BYTES-1];
  reg [7:0] common_ram [0:`SFBL_COMMON_BYTES-1];

  wire [3:0] cmd_op = command_word[3:0];
  wire cmd_to_file = command_word[`SFBL_CMD_TO_FILE_BIT];
  wire cmd_src_file = command_word[`SFBL_CMD_SRC_FILE_BIT];
  wire [2:0] cmd_bit = command_word[`SFBL_CMD_BIT_LSB +: 3];
  wire [6:0] cmd_ofs = command_word[`SFBL_CMD_OFS_LSB +: 7];
  wire [7:0] flags_view = {3'b000, wdog_expiry_flag, sleep_entered_flag,
    result_null_flag, nibble_overflow_flag, msb_overflow_flag};

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function [31:0] merge;
    input [31:0] old;
    input [31:0] new_val;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          merge[i*8 +: 8] = new_val[i*8 +: 8];
    end
  endfunction

  function addr_known;
    input [7:0] addr;
    begin
      addr_known = (addr[1:0] == 2'b00) && (addr <= `SFBL_LIN_DATA_OFS);
    end
  endfunction

  function [7:0] read_banked;
    input [3:0] region;
    input gpr_hit;
    input [7:0] gidx;
    input [6:0] ofs;
    begin
      read_banked = 8'h00;
      if (region[`SFBL_RG_COMMON])
        read_banked = common_ram[ofs[3:0]];
      else if (gpr_hit)
        read_banked = general_ram[gidx];
      else if (region[`SFBL_RG_CORE] && ofs == `SFBL_FLAGS_SLOT)
        read_banked = flags_view;
      else if (region[`SFBL_RG_CORE] && ofs == `SFBL_BSEL_SLOT)
        read_banked = {3'b000, bank_select_reg};
    end
  endfunction

  function [7:0] read_linear;
    input [11:0] ptr;
    begin
      read_linear = 8'h00;
      if (ptr < `SFBL_GPR_BYTES)
        read_linear = general_ram[ptr[7:0]];
    end
  endfunction

  // ----------------------------------------------------------------------
  // Address decode for the memory window and the instruction target
  // ----------------------------------------------------------------------
  wire [3:0] win_region;
  wire win_hit;
  wire [7:0] win_gidx;
  wire [3:0] ins_region;
  wire ins_hit;
  wire [7:0] ins_gidx;

  // Bank number times 80 plus offset less 20h gives the linear general RAM index
  sfbl_bank_decode u_win_dec (
    .bank(bank_select_reg),
    .offset(win_offset),
    .region(win_region),
    .gpr_hit(win_hit),
    .gpr_index(win_gidx)
  );

  sfbl_bank_decode u_ins_dec (
    .bank(bank_select_reg),
    .offset(cmd_ofs),
    .region(ins_region),
    .gpr_hit(ins_hit),
    .gpr_index(ins_gidx)
  );

  // ----------------------------------------------------------------------
  // Operation execute
  // ----------------------------------------------------------------------
  wire [7:0] src_value = cmd_src_file ?
    read_banked(ins_region, ins_hit, ins_gidx, cmd_ofs) : lit_operand;
  wire [7:0] alu_result;
  wire alu_wr;
  wire alu_z;
  wire alu_z_upd;
  wire alu_dc;
  wire alu_dc_upd;
  wire alu_c;
  wire alu_c_upd;

  sfbl_alu u_alu (
    .op(cmd_op),
    .a(src_value),
    .w(wreg_operand),
    .bit_sel(cmd_bit),
    .carry_in(msb_overflow_flag),
    .result(alu_result),
    .wr_en(alu_wr),
    .z(alu_z),
    .z_upd(alu_z_upd),
    .dc(alu_dc),
    .dc_upd(alu_dc_upd),
    .c(alu_c),
    .c_upd(alu_c_upd)
  );

  wire dest_write = exec && cmd_to_file && alu_wr;
  wire dest_core = ins_region[`SFBL_RG_CORE];
  wire dest_flags = dest_write && dest_core && (cmd_ofs == `SFBL_FLAGS_SLOT);
  wire any_upd = alu_z_upd || alu_dc_upd || alu_c_upd;
  wire [31:0] ptr_merged = merge({20'h00000, indirect_pointer}, s_axi_wdata, s_axi_wstrb);

  // ----------------------------------------------------------------------
  // AXI4-Lite handshakes
  // ----------------------------------------------------------------------
  wire wr_go = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
  wire rd_go = s_axi_arready && s_axi_arvalid;
  wire wr_lane0 = wr_go && s_axi_wstrb[0];
  wire wr_flags = wr_lane0 && (s_axi_awaddr == `SFBL_FLAGS_OFS);
  wire wr_win = wr_lane0 && (s_axi_awaddr == `SFBL_WIN_DATA_OFS);
  wire win_core = win_region[`SFBL_RG_CORE];

  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SFBL_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `SFBL_RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
    end
    else
    begin
      s_axi_awready <= !s_axi_awready && s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
      s_axi_wready <= !s_axi_awready && s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_known(s_axi_awaddr) ? `SFBL_RESP_OKAY : `SFBL_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
      if (rd_go)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= addr_known(s_axi_araddr) ? `SFBL_RESP_OKAY : `SFBL_RESP_SLVERR;
        case (s_axi_araddr)
          `SFBL_FLAGS_OFS: s_axi_rdata <= {24'h000000, flags_view};
          `SFBL_BANK_OFS: s_axi_rdata <= {27'h0000000, bank_select_reg};
          `SFBL_OPERAND_OFS: s_axi_rdata <= {16'h0000, wreg_operand, lit_operand};
          `SFBL_COMMAND_OFS: s_axi_rdata <= command_word;
          `SFBL_RESULT_OFS: s_axi_rdata <= {24'h000000, result_reg};
          `SFBL_WIN_OFS_OFS: s_axi_rdata <= {25'h0000000, win_offset};
          `SFBL_WIN_DATA_OFS: s_axi_rdata <= {24'h000000,
            read_banked(win_region, win_hit, win_gidx, win_offset)};
          `SFBL_LIN_PTR_OFS: s_axi_rdata <= {20'h00000, indirect_pointer};
          `SFBL_LIN_DATA_OFS: s_axi_rdata <= {24'h000000, read_linear(indirect_pointer)};
          default: s_axi_rdata <= 32'h0000_0000;
        endcase
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------------
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      bank_select_reg <= 5'h00;
      lit_operand <= 8'h00;
      wreg_operand <= 8'h00;
      command_word <= 32'h0000_0000;
      exec <= 1'b0;
      win_offset <= 7'h00;
      indirect_pointer <= 12'h000;
      result_reg <= 8'h00;
    end
    else
    begin
      exec <= wr_go && (s_axi_awaddr == `SFBL_COMMAND_OFS);
      if (wr_lane0 && s_axi_awaddr == `SFBL_BANK_OFS)
        bank_select_reg <= s_axi_wdata[4:0];
      if (wr_win && win_core && win_offset == `SFBL_BSEL_SLOT)
        bank_select_reg <= s_axi_wdata[4:0];
      if (dest_write && dest_core && cmd_ofs == `SFBL_BSEL_SLOT)
        bank_select_reg <= alu_result[4:0];
      if (wr_go && s_axi_awaddr == `SFBL_OPERAND_OFS)
      begin
        if (s_axi_wstrb[0])
          lit_operand <= s_axi_wdata[7:0];
        if (s_axi_wstrb[1])
          wreg_operand <= s_axi_wdata[15:8];
      end
      if (wr_go && s_axi_awaddr == `SFBL_COMMAND_OFS)
        command_word <= merge(command_word, s_axi_wdata, s_axi_wstrb);
      if (wr_lane0 && s_axi_awaddr == `SFBL_WIN_OFS_OFS)
        win_offset <= s_axi_wdata[6:0];
      if (wr_go && s_axi_awaddr == `SFBL_LIN_PTR_OFS)
        indirect_pointer <= ptr_merged[11:0];
      if (exec && alu_wr)
        result_reg <= alu_result;
    end
  end

  // ----------------------------------------------------------------------
  // Flag register
  // ----------------------------------------------------------------------
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      wdog_expiry_flag <= `SFBL_TO_RST;
      sleep_entered_flag <= `SFBL_PD_RST;
      result_null_flag <= `SFBL_Z_RST;
      nibble_overflow_flag <= `SFBL_DC_RST;
      msb_overflow_flag <= `SFBL_C_RST;
    end
    else
    begin
      // A kick or sleep in the same cycle as a time-out wins
      if (wdog_timeout)
        wdog_expiry_flag <= 1'b0;
      if (exec && cmd_op == `SFBL_OP_WDOG_KICK)
      begin
        wdog_expiry_flag <= 1'b1;
        sleep_entered_flag <= 1'b1;
      end
      if (exec && cmd_op == `SFBL_OP_SLEEP)
      begin
        wdog_expiry_flag <= 1'b1;
        sleep_entered_flag <= 1'b0;
      end
      // Plain stores reach the arithmetic flags only; bits 4 and 3 stay
      if (wr_flags || (wr_win && win_core && win_offset == `SFBL_FLAGS_SLOT))
      begin
        result_null_flag <= s_axi_wdata[`SFBL_Z_BIT];
        nibble_overflow_flag <= s_axi_wdata[`SFBL_DC_BIT];
        msb_overflow_flag <= s_axi_wdata[`SFBL_C_BIT];
      end
      if (dest_flags && !any_upd)
      begin
        result_null_flag <= alu_result[`SFBL_Z_BIT];
        nibble_overflow_flag <= alu_result[`SFBL_DC_BIT];
        msb_overflow_flag <= alu_result[`SFBL_C_BIT];
      end
      // Flag-updating operations overrule their own write to this register
      if (exec && alu_z_upd)
        result_null_flag <= alu_z;
      if (exec && alu_dc_upd)
        nibble_overflow_flag <= alu_dc;
      if (exec && alu_c_upd)
        msb_overflow_flag <= alu_c;
    end
  end

  // ----------------------------------------------------------------------
  // Data memory
  // ----------------------------------------------------------------------
  always @(posedge sys_clk)
  begin
    if (dest_write && ins_region[`SFBL_RG_COMMON])
      common_ram[cmd_ofs[3:0]] <= alu_result;
    if (dest_write && ins_hit)
      general_ram[ins_gidx] <= alu_result;
    if (wr_win && win_region[`SFBL_RG_COMMON])
      common_ram[win_offset[3:0]] <= s_axi_wdata[7:0];
    if (wr_win && win_hit)
      general_ram[win_gidx] <= s_axi_wdata[7:0];
    if (wr_lane0 && s_axi_awaddr == `SFBL_LIN_DATA_OFS && indirect_pointer < `SFBL_GPR_BYTES)
      general_ram[indirect_pointer[7:0]] <= s_axi_wdata[7:0];
  end

endmodule

/* testbench/sfbl_top_sva.sv */
// Purpose: Port checks for the flag register block
// Assumes: One clock, synchronous reset
// Notes: Bound to every sfbl_top
`timescale 1ns/1ps
`include "sfbl_regs.vh"
module sfbl_top_sva (
  input wire sys_clk,
  input wire sys_rst,
  input wire wdog_timeout,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire wdog_expiry_flag,
  input wire sleep_entered_flag
);
  reg run_vld;
  reg [3:0] run_op;
  reg [7:0] rd_adr;
  wire kick = run_vld && run_op == `SFBL_OP_WDOG_KICK;
  wire slp = run_vld && run_op == `SFBL_OP_SLEEP;
  // Operation executing this cycle
  always @(posedge sys_clk)
  begin
    run_vld <= !sys_rst && s_axi_awvalid && s_axi_awready && s_axi_wstrb[0]
      && s_axi_awaddr == `SFBL_COMMAND_OFS;
    run_op <= s_axi_wdata[3:0];
    rd_adr <= (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : rd_adr;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_reset_flags: assert property ($fell(sys_rst) |-> wdog_expiry_flag && sleep_entered_flag)
    else $error("reset flags wrong");
  a_tmo_clears: assert property (wdog_timeout && !kick && !slp |=> !wdog_expiry_flag)
    else $error("expiry flag not cleared");
  a_kick_sets: assert property (kick |=> wdog_expiry_flag && sleep_entered_flag)
    else $error("kick did not set flags");
  a_sleep_sets: assert property (slp |=> wdog_expiry_flag && !sleep_entered_flag)
    else $error("sleep flags wrong");
  a_status_held: assert property (!wdog_timeout && !kick && !slp |=>
    $stable(wdog_expiry_flag) && $stable(sleep_entered_flag))
    else $error("status flag changed");
  a_upper_zero: assert property (s_axi_rvalid && rd_adr == `SFBL_FLAGS_OFS |->
    s_axi_rdata[31:5] == 27'h0)
    else $error("flag upper bits set");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
    else $error("no write response");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read data");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("response dropped");
  a_bad_addr: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_awaddr > `SFBL_LIN_DATA_OFS |=> s_axi_bresp == `SFBL_RESP_SLVERR)
    else $error("unmapped write accepted");
  c_kick: cover property (kick);
  c_sleep: cover property (slp);
  c_tmo: cover property (wdog_timeout ##1 !wdog_expiry_flag);
endmodule

bind sfbl_top sfbl_top_sva u_chk (.*);

/* testbench/test_sfbl_top.sv */
// Purpose: Directed bus tests of the flag register block
// Assumes: AXI4-Lite master in tasks, 125 MHz clock
// Notes: Every wait is bounded
`timescale 1ns/1ps
`include "sfbl_regs.vh"
module test_sfbl_top;
  logic sys_clk, sys_rst = 1, wdog_timeout = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic wdog_expiry_flag, sleep_entered_flag;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int err_total = 0, num_checks = 0;
  localparam logic [1:0] OK = `SFBL_RESP_OKAY;
  localparam logic [7:0] FL = `SFBL_FLAGS_OFS, WD = `SFBL_WIN_DATA_OFS;
  localparam logic [7:0] LP = `SFBL_LIN_PTR_OFS, LD = `SFBL_LIN_DATA_OFS;

  sfbl_top DUT (.*);

  initial
  begin
    sys_clk = 0;
    forever #4 sys_clk = ~sys_clk;
  end

  // ----
  // Bus tasks
  // ----
  task chk(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task hang(input int n);
    if (n >= 40)
    begin
      err_total++;
      end_of_test();
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = OK);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    @(posedge sys_clk);
    for (n = 1; s_axi_awready !== 1 && n < 40; n++) @(posedge sys_clk);
    chk("wready", 1, s_axi_wready);
    s_axi_awvalid <= 0;
    s_axi_wvalid <= 0;
    s_axi_bready <= 1;
    for (; s_axi_bvalid !== 1 && n < 40; n++) @(posedge sys_clk);
    s_axi_bready <= 0;
    hang(n);
    chk("bresp", er, s_axi_bresp);
  endtask

  task rd(input string nm, input logic [7:0] a, input logic [31:0] e,
    input logic [1:0] er = OK);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    @(posedge sys_clk);
    for (n = 1; s_axi_arready !== 1 && n < 40; n++) @(posedge sys_clk);
    s_axi_arvalid <= 0;
    s_axi_rready <= 1;
    for (; s_axi_rvalid !== 1 && n < 40; n++) @(posedge sys_clk);
    s_axi_rready <= 0;
    hang(n);
    chk(nm, e, s_axi_rdata);
    chk("rresp", er, s_axi_rresp);
  endtask

  task op(input logic [3:0] o, input logic [7:0] a, w, input logic [1:0] f = 0,
    input logic [2:0] b = 0, input logic [6:0] s = `SFBL_FLAGS_SLOT);
    wr(`SFBL_OPERAND_OFS, {16'h0, w, a});
    wr(`SFBL_COMMAND_OFS, {9'h0, s, 7'h0, b, f, o});
  endtask

  task alu(input logic [3:0] o, input logic [7:0] a, w, r, input logic [2:0] fl);
    op(o, a, w);
    rd("result", `SFBL_RESULT_OFS, r);
    rd("flags", FL, {27'h3, fl});
  endtask

  task win(input logic [4:0] b, input logic [6:0] o);
    wr(`SFBL_BANK_OFS, b);
    wr(`SFBL_WIN_OFS_OFS, o);
  endtask

  task wb(input logic [4:0] b, input logic [6:0] o, input logic [7:0] d);
    win(b, o);
    wr(WD, d);
  endtask

  task rb(input logic [4:0] b, input logic [6:0] o, input logic [7:0] e);
    win(b, o);
    rd("window", WD, e);
  endtask

  task pulse;
    wdog_timeout <= 1;
    @(posedge sys_clk);
    wdog_timeout <= 0;
    @(posedge sys_clk);
  endtask

  // ----
  // Test sequence
  // ----
  initial
  begin
    repeat (6) @(posedge sys_clk);
    sys_rst <= 0;
    rd("flags", FL, 32'h18);
    for (int i = 1; i < 8; i++) rd("reg", 8'(i * 4), 0);
    chk("expiry", 1, wdog_expiry_flag);
    $display("reset test done");
    alu(`SFBL_OP_SUM, 8'h0f, 8'h01, 8'h10, 3'b010);
    alu(`SFBL_OP_SUM, 8'hff, 8'h01, 8'h00, 3'b111);
    alu(`SFBL_OP_SUM, 8'h12, 8'h34, 8'h46, 3'b000);
    alu(`SFBL_OP_DIFF, 8'h05, 8'h03, 8'h02, 3'b011);
    alu(`SFBL_OP_DIFF, 8'h07, 8'h07, 8'h00, 3'b111);
    alu(`SFBL_OP_DIFF, 8'h03, 8'h05, 8'hfe, 3'b000);
    alu(`SFBL_OP_XOR, 8'hff, 8'h0f, 8'hf0, 3'b000);
    alu(`SFBL_OP_OR, 8'h10, 8'h01, 8'h11, 3'b000);
    alu(`SFBL_OP_AND, 8'hf0, 8'h0f, 8'h00, 3'b100);
    alu(`SFBL_OP_ROT_L, 8'h81, 8'h00, 8'h02, 3'b101);
    alu(`SFBL_OP_ROT_R, 8'h02, 8'h00, 8'h81, 3'b100);
    $display("arithmetic test done");
    wr(FL, 32'hff);
    rd("flags", FL, 32'h1f);
    wr(FL, 32'h00);
    rd("flags", FL, 32'h18);
    wr(FL, 32'h03);
    op(`SFBL_OP_ZERO_FILE, 0, 0, 1);
    rd("flags", FL, 32'h1f);
    wr(FL, 32'h07);
    op(`SFBL_OP_SUM, 8'h01, 8'h01, 1);
    rd("flags", FL, 32'h18);
    $display("flag write test done");
    pulse();
    chk("expiry", 0, wdog_expiry_flag);
    rd("flags", FL, 32'h08);
    op(`SFBL_OP_SLEEP, 0, 0);
    rd("flags", FL, 32'h10);
    chk("sleep", 0, sleep_entered_flag);
    pulse();
    rd("flags", FL, 32'h00);
    op(`SFBL_OP_WDOG_KICK, 0, 0);
    rd("flags", FL, 32'h18);
    $display("watchdog test done");
    op(`SFBL_OP_WREG_STORE, 0, 8'h05, 2'b01);
    rd("flags", FL, 32'h1d);
    op(`SFBL_OP_BIT_DROP, 0, 0, 2'b11, 3'd0);
    rd("flags", FL, 32'h1c);
    op(`SFBL_OP_BIT_RAISE, 0, 0, 2'b11, 3'd1);
    rd("flags", FL, 32'h1e);
    op(`SFBL_OP_NIBBLE_EXCH, 0, 0, 2'b11);
    rd("result", `SFBL_RESULT_OFS, 8'he1);
    rd("flags", FL, 32'h19);
    op(`SFBL_OP_SUM, 8'h10, 8'h05, 2'b01, 0, 7'h71);
    rb(0, 7'h71, 8'h15);
    rd("flags", FL, 32'h18);
    $display("flagless store test done");
    wb(0, 7'h70, 8'ha5);
    wb(0, 7'h7f, 8'h5a);
    rb(3, 7'h70, 8'ha5);
    rb(31, 7'h7f, 8'h5a);
    wb(0, 7'h20, 8'h11);
    wb(1, 7'h20, 8'h22);
    rb(0, 7'h20, 8'h11);
    wb(0, 7'h6f, 8'h33);
    wr(LP, 79);
    rd("linear", LD, 8'h33);
    wr(LP, 80);
    rd("linear", LD, 8'h22);
    wr(LD, 8'h44);
    rb(1, 7'h20, 8'h44);
    wb(2, 7'h0c, 8'hff);
    rb(2, 7'h0c, 8'h00);
    rb(2, 7'h1f, 8'h00);
    rb(5, `SFBL_FLAGS_SLOT, 8'h18);
    rb(5, `SFBL_BSEL_SLOT, 8'h05);
    rd("unmapped", 8'h24, 0, `SFBL_RESP_SLVERR);
    wr(8'h28, 1, `SFBL_RESP_SLVERR);
    $display("memory test done");
    end_of_test();
  end
endmodule
